// ---- sipo_map.vh ----
`ifndef SIPO_MAP_VH
`define SIPO_MAP_VH

// Shift register geometry
`define SIPO_STAGES        8
`define SIPO_MSB           7
`define SIPO_CNT_W         3
`define SIPO_CNT_LAST      3'h7
`define SIPO_CNT_ONE       3'h1
`define SIPO_CNT_RST       3'h0

// Reset values
`define SIPO_STAGE_RST     1'h0
`define SIPO_WORD_RST      8'h00
`define SIPO_FLAG_RST      1'h0

// Completed word tally
`define SIPO_TALLY_W       16
`define SIPO_TALLY_RST     16'h0000
`define SIPO_TALLY_ONE     16'h0001
`define SIPO_TALLY_MAX     16'hffff

// Word buffer geometry
`define SIPO_FIFO_DEPTH    32
`define SIPO_FIFO_AW       5
`define SIPO_FIFO_LVL_W    6

`endif

// ---- sipo_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

`include "sipo_map.vh"

// Small synchronous FIFO; read data leave through a register stage
module sipo_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SIPO_FIFO_DEPTH,
  parameter AW    = `SIPO_FIFO_AW,
  parameter LW    = `SIPO_FIFO_LVL_W
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [LW-1:0]    level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [LW-1:0]    cnt_ff;
  reg [WIDTH-1:0] out_data_ff;
  reg             out_valid_ff;

  wire            do_push;
  wire            do_load;

  // Pointer step with wrap; shared by both ends
  function [AW-1:0] ptr_next;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        ptr_next = {AW{1'b0}};
      end else begin
        ptr_next = p + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // Full only counts the array; the output stage is one extra slot
  assign in_ready  = (cnt_ff != DEPTH[LW-1:0]);
  assign do_push   = in_valid && in_ready;
  assign do_load   = (cnt_ff != {LW{1'b0}}) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;
  assign level     = cnt_ff;

  // Storage array, no reset needed
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers, occupancy and registered read port
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      cnt_ff       <= {LW{1'b0}};
      out_data_ff  <= {WIDTH{1'b0}};
      out_valid_ff <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= ptr_next(wr_ptr_ff);
      end
      if (do_load) begin
        rd_ptr_ff   <= ptr_next(rd_ptr_ff);
        out_data_ff <= mem[rd_ptr_ff];
      end
      if (do_push && !do_load) begin
        cnt_ff <= cnt_ff + {{(LW-1){1'b0}}, 1'b1};
      end else if (!do_push && do_load) begin
        cnt_ff <= cnt_ff - {{(LW-1){1'b0}}, 1'b1};
      end
      if (do_load) begin
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- sipo_shift_register.v ----
// Behaviour
// - Eight D stages, all visible in parallel
// - Each rising edge shifts first toward eighth
// - First stage loads AND of gate inputs
// - Later stages take predecessor's pre-edge value
// - Low clear empties all stages at once
// - No edge, clear high: stages hold
// - Gate inputs sampled only at rising edge
`timescale 1ns/1ps
`default_nettype none

`include "sipo_map.vh"

module sipo_shift_register (
  input  wire                     clk,
  input  wire                     sys_rst,
  input  wire                     clear_n,
  input  wire                     gate_a,
  input  wire                     gate_b,
  output wire [`SIPO_MSB:0]       par_q,
  output wire                     ser_out,
  output wire                     word_valid,
  input  wire                     word_ready,
  output wire [`SIPO_MSB:0]       word_data,
  output wire                     word_in_ready,
  output wire [`SIPO_FIFO_LVL_W-1:0] word_level,
  output wire                     word_overflow,
  output wire [`SIPO_TALLY_W-1:0] word_tally
);

  // Stage storage, one flop per bit
  reg  [`SIPO_MSB:0]       stage_ff;
  wire                     in_bit;
  wire [`SIPO_MSB:0]       nxt_stage;

  // Framing of completed words
  reg  [`SIPO_CNT_W-1:0]   bit_cnt_ff;
  wire [`SIPO_CNT_W-1:0]   nxt_bit_cnt;
  wire                     word_done;

  // Buffer side signals
  wire                     fifo_in_ready;
  wire                     push_lost;

  // Status flops
  reg                      overflow_ff;
  reg  [`SIPO_TALLY_W-1:0] tally_ff;
  reg  [`SIPO_TALLY_W-1:0] nxt_tally;

  // Either gate low forces a zero into the first stage
  assign in_bit = gate_a & gate_b;

  // Next contents: new bit in front, the rest one step on
  assign nxt_stage[0] = in_bit;

  genvar gi;
  generate
    for (gi = 1; gi < `SIPO_STAGES; gi = gi + 1) begin : g_link
      // Each later stage sees its predecessor's current value
      assign nxt_stage[gi] = stage_ff[gi-1];
    end
  endgenerate

  // Stage flops; clear is asynchronous so it wins without an edge.
  // Gate inputs are read only here, at the clock edge.
  generate
    for (gi = 0; gi < `SIPO_STAGES; gi = gi + 1) begin : g_stage
      always @(posedge clk or posedge sys_rst or negedge clear_n) begin
        if (sys_rst) begin
          stage_ff[gi] <= `SIPO_STAGE_RST;
        end else if (!clear_n) begin
          stage_ff[gi] <= `SIPO_STAGE_RST;
        end else begin
          stage_ff[gi] <= nxt_stage[gi];
        end
      end
    end
  endgenerate

  // Outputs come straight from the stage flops, so between edges
  // only clear or reset can move them.
  assign par_q   = stage_ff;
  assign ser_out = stage_ff[`SIPO_MSB];

  // Bit counter marks every eighth shift as the end of a word.
  // Clear realigns framing with the emptied register.
  assign word_done   = (bit_cnt_ff == `SIPO_CNT_LAST);
  assign nxt_bit_cnt = bit_cnt_ff + `SIPO_CNT_ONE;

  always @(posedge clk or posedge sys_rst or negedge clear_n) begin
    if (sys_rst) begin
      bit_cnt_ff <= `SIPO_CNT_RST;
    end else if (!clear_n) begin
      bit_cnt_ff <= `SIPO_CNT_RST;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // Word buffer: the pushed word is the content after this edge,
  // so no extra pipeline stage sits between shift and buffer.
  // The shifter cannot stall, so back-pressure is shown on a port.
  sipo_fifo #(
    .WIDTH (`SIPO_STAGES),
    .DEPTH (`SIPO_FIFO_DEPTH),
    .AW    (`SIPO_FIFO_AW),
    .LW    (`SIPO_FIFO_LVL_W)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (word_done),
    .in_ready  (fifo_in_ready),
    .in_data   (nxt_stage),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data),
    .level     (word_level)
  );

  assign word_in_ready = fifo_in_ready;
  assign push_lost     = word_done && !fifo_in_ready;

  // Sticky overflow: a word finished while the buffer was full.
  // Only clear or reset drops it, and those also restart framing.
  always @(posedge clk or posedge sys_rst or negedge clear_n) begin
    if (sys_rst) begin
      overflow_ff <= `SIPO_FLAG_RST;
    end else if (!clear_n) begin
      overflow_ff <= `SIPO_FLAG_RST;
    end else if (push_lost) begin
      overflow_ff <= 1'b1;
    end
  end

  // Count of words accepted into the buffer, saturating
  always @* begin
    nxt_tally = tally_ff;
    if (word_done && fifo_in_ready && (tally_ff != `SIPO_TALLY_MAX)) begin
      nxt_tally = tally_ff + `SIPO_TALLY_ONE;
    end
  end

  // Tally survives clear; it tracks history, not register content
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tally_ff <= `SIPO_TALLY_RST;
    end else begin
      tally_ff <= nxt_tally;
    end
  end

  assign word_overflow = overflow_ff;
  assign word_tally    = tally_ff;

endmodule

`default_nettype wire

// ---- sipo_shift_register_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sipo_map.vh"
// Stage relations seen at rising edges, plus a falling-edge snapshot
module sipo_shift_register_chk (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               clear_n,
  input wire logic               gate_a,
  input wire logic               gate_b,
  input wire logic [`SIPO_MSB:0] par_q,
  input wire logic               ser_out,
  input wire logic               word_valid,
  input wire logic               word_ready,
  input wire logic [`SIPO_MSB:0] word_data
);
  logic [7:0] mid_q_ff;
  // Mid-cycle snapshot, proves nothing moves between edges
  always @(negedge clk) mid_q_ff <= par_q;
  logic [3:0] clr_run_ff;
  // Edges since clear or reset, capped once eight bits have entered
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) clr_run_ff <= 4'h0;
    else if (!clear_n) clr_run_ff <= 4'h0;
    else if (clr_run_ff != 4'h8) clr_run_ff <= clr_run_ff + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_clr; !clear_n |-> par_q == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear missed");
  property p_all; clear_n ##1 clear_n |->
    par_q == {$past(par_q[6:0]), $past(gate_a & gate_b)}; endproperty
  a_all: assert property (p_all) else $error("bad word");
  property p_first; clear_n ##1 clear_n |->
    par_q[0] == $past(gate_a & gate_b); endproperty
  a_first: assert property (p_first) else $error("bad entry");
  property p_next; clear_n ##1 clear_n |->
    par_q[7:1] == $past(par_q[6:0]); endproperty
  a_next: assert property (p_next) else $error("bad shift");
  property p_far; clr_run_ff == 4'h8 && clear_n |->
    par_q[7] == $past(gate_a & gate_b, 8); endproperty
  a_far: assert property (p_far) else $error("bad depth");
  property p_hold; clear_n |-> par_q == mid_q_ff; endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_ser; clear_n ##1 clear_n |-> ser_out == $past(par_q[6]);
  endproperty
  a_ser: assert property (p_ser) else $error("bad cascade");
  property p_stall; word_valid && !word_ready |=>
    word_valid && $stable(word_data); endproperty
  a_stall: assert property (p_stall) else $error("word lost");
endmodule
bind sipo_shift_register sipo_shift_register_chk chk_u (.clk(clk),
  .sys_rst(sys_rst), .clear_n(clear_n), .gate_a(gate_a), .gate_b(gate_b),
  .par_q(par_q), .ser_out(ser_out), .word_valid(word_valid),
  .word_ready(word_ready), .word_data(word_data));
`default_nettype wire

// ---- sipo_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Upstream driver of the serial gates
module sipo_src_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic fix_a,
  input  wire logic fix_b,
  output var logic  gate_a,
  output var logic  gate_b
);
  // Falling edge only, so setup and hold stay clear of the rise
  always @(negedge clk) begin
    gate_a <= run ? 1'($urandom) : fix_a;
    gate_b <= run ? 1'($urandom) : fix_b;
  end
endmodule
`default_nettype wire

// ---- sipo_shift_register_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sipo_map.vh"
module sipo_shift_register_tb_top;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clear_n = 1'b1;
  logic       run = 1'b0;
  logic       fix_a = 1'b0;
  logic       fix_b = 1'b0;
  logic       word_ready = 1'b1;
  logic [7:0] exp_q = 8'h00;
  logic [2:0] bit_cnt = 3'h0;
  logic       exp_ovf = 1'b0;
  logic [7:0] words[$];
  int         mismatches = 0;
  int         num_checks = 0;
  int         pushed = 0;
  wire logic  gate_a, gate_b, ser_out, word_valid, word_in_ready, word_ovf;
  wire logic [7:0]  par_q, word_data;
  wire logic [15:0] word_tally;
  wire logic [5:0]  word_level;
  always #5 clk = ~clk;
  sipo_src_model src_u (.clk(clk), .run(run), .fix_a(fix_a), .fix_b(fix_b),
    .gate_a(gate_a), .gate_b(gate_b));
  sipo_shift_register dut_u (.clk(clk), .sys_rst(sys_rst), .clear_n(clear_n),
    .gate_a(gate_a), .gate_b(gate_b), .par_q(par_q), .ser_out(ser_out),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .word_in_ready(word_in_ready), .word_level(word_level),
    .word_overflow(word_ovf), .word_tally(word_tally));
  function automatic logic [7:0] nxt_q(input logic [7:0] q, input logic b);
    return {q[6:0], b};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reference stages; a full array drops the word and flags it
  always @(posedge clk or posedge sys_rst or negedge clear_n) begin
    if (sys_rst || !clear_n) begin
      exp_q <= 8'h00;
      bit_cnt <= 3'h0;
      exp_ovf <= 1'b0;
    end else begin
      exp_q <= nxt_q(exp_q, gate_a & gate_b);
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && word_in_ready) begin
        words.push_back(nxt_q(exp_q, gate_a & gate_b));
        pushed++;
      end else if (bit_cnt == 3'h7) exp_ovf <= 1'b1;
    end
  end
  always @(posedge clk) begin
    if (!sys_rst && word_valid && word_ready)
      check(word_data, words.pop_front());
  end
  // Mid-cycle view of every stage
  always @(negedge clk) begin
    if (!sys_rst) begin
      check(par_q, exp_q);
      check({7'h0, ser_out}, {7'h0, exp_q[7]});
      check({7'h0, word_ovf}, {7'h0, exp_ovf});
    end
  end
  initial begin
    void'($urandom(65812));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    // Every gate combination, each held two edges
    for (int i = 0; i < 4; i++) begin
      {fix_a, fix_b} = 2'(i);
      repeat (2) @(negedge clk);
    end
    run = 1'b1;
    repeat (300) begin
      @(negedge clk);
      word_ready = 1'($urandom);
    end
    #2 clear_n = 1'b0;
    #1 check(par_q, 8'h00);
    @(negedge clk) clear_n = 1'b1;
    // Consumer stalls until the buffer refuses
    word_ready = 1'b0;
    repeat (300) @(negedge clk);
    check({7'h0, word_in_ready}, 8'h00);
    check({2'h0, word_level}, 8'h20);
    word_ready = 1'b1;
    clear_n = 1'b0;
    repeat (50) @(negedge clk);
    check({7'h0, word_valid}, 8'h00);
    check({2'h0, word_level}, 8'h00);
    check(word_tally[7:0], pushed[7:0]);
    clear_n = 1'b1;
    print_verdict;
  end
  initial begin
    #50000;
    mismatches++;
    print_verdict;
  end
endmodule
`default_nettype wire
